// ---- hdl/ccrb_consts.svh ----
// Constants of the charger control register bank: offsets, fields, resets, timing.
// Assumes a 20 MHz core clock; included by bare name from the design files.
// Overview of operation
// RULE1 - Not charging: offset bit adds 384mV to maximum target
// RULE2 - Trickle charging always adds 384mV to minimum
// RULE3 - Reverse turbo boost backs input when adapter overloads
// RULE4 - Host avoids reverse turbo in autonomous or low battery
// RULE5 - Comparator debounce: 2us, 12us, 2ms, 720us
// RULE6 - Exit bit leaves learn when battery below minimum
// RULE7 - Learn needs enable, absent input low, battery present
// RULE8 - Reverse output bit powers the adapter port
// RULE9 - Three-bit field overrides switching frequency, 1420-600kHz
// RULE10 - Host writes frequency field back unchanged to keep
// RULE11 - Force-off bit turns off battery FET, disables turbo
// RULE12 - Monitor disable only in battery-only operation
// RULE13 - Select bit routes adapter or battery monitor
// RULE14 - Low system reference 5.4V to 6.8V, default 6.0V
// RULE15 - Trickle current 32mA steps, default 128mA
// RULE16 - Fault debounce 1.3s, or 150ms when bit set
// RULE17 - Hot debounce 7us/100us/500us/1ms, low-voltage fixed 2us
// RULE18 - Hot output held minimum coded time once asserted
// RULE19 - Profile bits combine; nonzero turns thermistor source on
// RULE20 - Comparator reference 1.2V or 2V, not battery-only
// RULE21 - Comparator bit disables comparator, pin becomes interrupt
// RULE22 - Polarity bit inverts comparator output
// RULE23 - Sixteen-bit words; reserved bits read zero, ignore writes (only control word zero masks them; words one and two store every bit)
`ifndef CCRB_CONSTS_SVH
`define CCRB_CONSTS_SVH

// Bus
`define CCRB_SMB_ADDR       7'h09
`define CCRB_OFS_CTRL0      8'h39
`define CCRB_OFS_CTRL1      8'h3c
`define CCRB_OFS_CTRL2      8'h3d
`define CCRB_BYTE_BITS      4'h8

// Reset values and masks
`define CCRB_CTRL0_MASK     16'h0003
`define CCRB_CTRL0_RST      16'h0000
`define CCRB_CTRL1_RST      16'h0003
`define CCRB_CTRL2_RST      16'h6000

// Field positions
`define CCRB_C0_OFFSET      1
`define CCRB_C0_REVTURBO    0
`define CCRB_C1_CMPDB       15:14
`define CCRB_C1_EXITLEARN   13
`define CCRB_C1_LEARN       12
`define CCRB_C1_REVOUT      11
`define CCRB_C1_SUPPL       10
`define CCRB_C1_FREQ        9:7
`define CCRB_C1_FREQ_LSB    7
`define CCRB_C1_FETOFF      6
`define CCRB_C1_IMONDIS     5
`define CCRB_C1_IMONSEL     4
`define CCRB_C1_LOWREF      2:0
`define CCRB_C2_TRICKLE     15:13
`define CCRB_C2_FAULTSHORT  11
`define CCRB_C2_HOTDB       10:9
`define CCRB_C2_HOLD        8:6
`define CCRB_C2_PROFHI      5
`define CCRB_C2_CMPREF      4
`define CCRB_C2_CMPDIS      3
`define CCRB_C2_CMPPOL      2

// Timing
`define CCRB_CLK_HZ         20000000
`define CCRB_CYC_US(t)      ((t) * (`CCRB_CLK_HZ / 1000000))
`define CCRB_CYC_MS(t)      ((t) * (`CCRB_CLK_HZ / 1000))
`define CCRB_CMP_DB0_US     2
`define CCRB_CMP_DB1_US     12
`define CCRB_CMP_DB2_MS     2
`define CCRB_CMP_DB3_US     720
`define CCRB_FAULT_LONG_MS  1300
`define CCRB_FAULT_SHORT_MS 150
`define CCRB_HOT_DB0_US     7
`define CCRB_HOT_DB1_US     100
`define CCRB_HOT_DB2_US     500
`define CCRB_HOT_DB3_MS     1
`define CCRB_LOW_DB_US      2
`define CCRB_HOLD0_MS       10
`define CCRB_HOLD1_MS       20
`define CCRB_HOLD2_MS       15
`define CCRB_HOLD3_MS       5
`define CCRB_HOLD4_MS       1
`define CCRB_HOLD5_US       500
`define CCRB_HOLD6_US       100
`define CCRB_HOLD7_CYC      1

`endif

// ---- hdl/ccrb_pkg.sv ----
// Types shared by the charger control register bank.
// No dependencies.
package ccrb_pkg;
  typedef enum logic [2:0] {
    SMB_IDLE = 3'h0,
    SMB_ADDR = 3'h1,
    SMB_CMD  = 3'h3,
    SMB_WR   = 3'h2,
    SMB_RD   = 3'h6,
    SMB_WAIT = 3'h7
  } ccrb_smb_state_type;
endpackage

// ---- hdl/ccrb_debounce.sv ----
// Assertion debounce: level rises once the input has stayed high for limit cycles.
// Assumes rawIn is synchronous to core_clk; release is immediate.
`timescale 1ns/1ps
module ccrb_debounce (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        rawIn,
  input  wire logic [31:0] limit,
  output logic             level_ff
);
  logic [31:0] cnt_ff;

  always_ff @(posedge core_clk) begin
    if (rst || !rawIn) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff < limit) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  // Limit change mid-count takes effect at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= rawIn && (cnt_ff >= limit);
    end
  end
endmodule

// ---- hdl/ccrb_top.sv ----
// Charger control register bank: two-wire management bus slave and control words.
// Assumes bus pins and status inputs are synchronous to core_clk.
`timescale 1ns/1ps
`include "ccrb_consts.svh"
module ccrb_top #(
  parameter int unsigned CMP_DB2_CYC    = `CCRB_CYC_MS(`CCRB_CMP_DB2_MS),
  parameter int unsigned CMP_DB3_CYC    = `CCRB_CYC_US(`CCRB_CMP_DB3_US),
  parameter int unsigned FAULT_LONG_CYC = `CCRB_CYC_MS(`CCRB_FAULT_LONG_MS),
  parameter int unsigned FAULT_SHRT_CYC = `CCRB_CYC_MS(`CCRB_FAULT_SHORT_MS),
  parameter int unsigned HOT_DB2_CYC    = `CCRB_CYC_US(`CCRB_HOT_DB2_US),
  parameter int unsigned HOT_DB3_CYC    = `CCRB_CYC_MS(`CCRB_HOT_DB3_MS),
  parameter int unsigned HOLD0_CYC      = `CCRB_CYC_MS(`CCRB_HOLD0_MS),
  parameter int unsigned HOLD1_CYC      = `CCRB_CYC_MS(`CCRB_HOLD1_MS),
  parameter int unsigned HOLD2_CYC      = `CCRB_CYC_MS(`CCRB_HOLD2_MS),
  parameter int unsigned HOLD3_CYC      = `CCRB_CYC_MS(`CCRB_HOLD3_MS),
  parameter int unsigned HOLD4_CYC      = `CCRB_CYC_MS(`CCRB_HOLD4_MS),
  parameter int unsigned HOLD5_CYC      = `CCRB_CYC_US(`CCRB_HOLD5_US)
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       smbClkIn,
  input  wire logic       smbDatIn,
  output logic            smbDatOut_ff,
  output logic            smbDatOe_ff,
  input  wire logic [2:0] progFreqCode,
  input  wire logic       charging,
  input  wire logic       trickleCharging,
  input  wire logic       hybridConfig,
  input  wire logic       nvdcConfig,
  input  wire logic       adapterOverLimit,
  input  wire logic       adapterPresent,
  input  wire logic       batteryAbsentInput,
  input  wire logic       batteryPresent,
  input  wire logic       vbatBelowMinSys,
  input  wire logic       profileLowBit,
  input  wire logic       comparatorAbove,
  input  wire logic       adapterHotReq,
  input  wire logic       batteryHotReq,
  input  wire logic       lowSysHotReq,
  input  wire logic       faultReq,
  output logic            sysVoltOffsetOn_ff,
  output logic            minSysOffsetOn_ff,
  output logic            reverseTurboRun_ff,
  output logic            learnActive_ff,
  output logic            reverseOutputOn_ff,
  output logic            supplementalOn_ff,
  output logic [2:0]      switchFreqCode_ff,
  output logic            batteryFetOff_ff,
  output logic            turboAllowed_ff,
  output logic            currentMonitorOn_ff,
  output logic            monitorSelBattery_ff,
  output logic [2:0]      lowSysRefCode_ff,
  output logic [2:0]      trickleCode_ff,
  output logic            faultShutdown_ff,
  output logic            processorHotOe_ff,
  output logic [1:0]      thermistorProfile_ff,
  output logic            thermistorSourceOn_ff,
  output logic            comparatorRefHigh_ff,
  output logic            comparatorOutput_ff,
  output logic            comparatorPinIntMode_ff
);
  ccrb_pkg::ccrb_smb_state_type state_ff;
  logic        sclPrev_ff, sdaPrev_ff, ackPhase_ff, masterNack_ff, byteIdx_ff, wrStb_ff;
  logic [3:0]  bitCnt_ff;
  logic [7:0]  shift_ff, ptr_ff, lowByte_ff, txByte_ff;
  logic [15:0] rdHold_ff, wrData_ff, word0_ff, word1_ff, word2_ff, rdWord;
  logic        sclRise, sclFall, startCond, stopCond, addrMatch;
  logic [31:0] cmpLimit, faultLimit, hotLimit, holdLimit, lowLimit, holdCnt_ff;
  logic        cmpDeb, faultDeb, acHotDeb, dcHotDeb, lowHotDeb, anyHot;
  assign sclRise   = smbClkIn && !sclPrev_ff;
  assign sclFall   = !smbClkIn && sclPrev_ff;
  assign startCond = sclPrev_ff && smbClkIn && sdaPrev_ff && !smbDatIn;
  assign stopCond  = sclPrev_ff && smbClkIn && !sdaPrev_ff && smbDatIn;
  assign addrMatch = (shift_ff[7:1] == `CCRB_SMB_ADDR);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclPrev_ff   <= 1'b1;
      sdaPrev_ff   <= 1'b1;
      smbDatOut_ff <= 1'b0;
    end else begin
      sclPrev_ff   <= smbClkIn;
      sdaPrev_ff   <= smbDatIn;
      smbDatOut_ff <= 1'b0;
    end
  end
  // Unmapped offsets read zero
  always_comb begin
    case (ptr_ff)
      `CCRB_OFS_CTRL0: rdWord = word0_ff & `CCRB_CTRL0_MASK; // RULE23
      `CCRB_OFS_CTRL1: rdWord = word1_ff;
      `CCRB_OFS_CTRL2: rdWord = word2_ff;
      default:         rdWord = 16'h0000;
    endcase
  end
  // Bus slave: SDA only moves while SCL is low, so our own drive never fakes a start or stop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff      <= ccrb_pkg::SMB_IDLE;
      bitCnt_ff     <= 4'h0;
      ackPhase_ff   <= 1'b0;
      masterNack_ff <= 1'b0;
      shift_ff      <= 8'h00;
      ptr_ff        <= 8'h00;
      lowByte_ff    <= 8'h00;
      byteIdx_ff    <= 1'b0;
      txByte_ff     <= 8'h00;
      rdHold_ff     <= 16'h0000;
      smbDatOe_ff   <= 1'b0;
      wrStb_ff      <= 1'b0;
      wrData_ff     <= 16'h0000;
    end else begin
      wrStb_ff <= 1'b0;
      if (startCond) begin
        state_ff    <= ccrb_pkg::SMB_ADDR;
        bitCnt_ff   <= 4'h0;
        ackPhase_ff <= 1'b0;
        smbDatOe_ff <= 1'b0;
      end else if (stopCond) begin
        state_ff    <= ccrb_pkg::SMB_IDLE;
        ackPhase_ff <= 1'b0;
        smbDatOe_ff <= 1'b0;
      end else if (state_ff != ccrb_pkg::SMB_IDLE && state_ff != ccrb_pkg::SMB_WAIT) begin
        if (sclRise && !ackPhase_ff && bitCnt_ff != `CCRB_BYTE_BITS) begin
          shift_ff  <= {shift_ff[6:0], smbDatIn};
          bitCnt_ff <= bitCnt_ff + 4'h1;
        end else if (sclRise && ackPhase_ff) begin
          masterNack_ff <= smbDatIn;
        end else if (sclFall && !ackPhase_ff && bitCnt_ff != 4'h0
                     && bitCnt_ff != `CCRB_BYTE_BITS && state_ff == ccrb_pkg::SMB_RD) begin
          smbDatOe_ff <= !txByte_ff[3'h7 - bitCnt_ff[2:0]];
        end else if (sclFall && !ackPhase_ff && bitCnt_ff == `CCRB_BYTE_BITS) begin
          ackPhase_ff <= 1'b1;
          case (state_ff)
            ccrb_pkg::SMB_ADDR: begin
              smbDatOe_ff <= addrMatch;
              rdHold_ff   <= rdWord;
            end
            ccrb_pkg::SMB_CMD: begin
              smbDatOe_ff <= 1'b1;
              ptr_ff      <= shift_ff;
              byteIdx_ff  <= 1'b0;
            end
            ccrb_pkg::SMB_WR: begin
              smbDatOe_ff <= 1'b1;
              byteIdx_ff  <= 1'b1;
              if (!byteIdx_ff) begin
                lowByte_ff <= shift_ff;
              end else begin
                wrStb_ff  <= 1'b1; // RULE23
                wrData_ff <= {shift_ff, lowByte_ff};
              end
            end
            default: smbDatOe_ff <= 1'b0;
          endcase
        end else if (sclFall && ackPhase_ff) begin
          ackPhase_ff <= 1'b0;
          bitCnt_ff   <= 4'h0;
          smbDatOe_ff <= 1'b0;
          case (state_ff)
            ccrb_pkg::SMB_ADDR: begin
              if (!addrMatch) begin
                state_ff <= ccrb_pkg::SMB_WAIT;
              end else if (shift_ff[0]) begin
                state_ff    <= ccrb_pkg::SMB_RD;
                txByte_ff   <= rdHold_ff[7:0];
                byteIdx_ff  <= 1'b1;
                smbDatOe_ff <= !rdHold_ff[7];
              end else begin
                state_ff <= ccrb_pkg::SMB_CMD;
              end
            end
            ccrb_pkg::SMB_CMD: state_ff <= ccrb_pkg::SMB_WR;
            ccrb_pkg::SMB_RD: begin
              if (masterNack_ff) begin
                state_ff <= ccrb_pkg::SMB_WAIT;
              end else begin
                txByte_ff   <= byteIdx_ff ? rdHold_ff[15:8] : 8'h00;
                smbDatOe_ff <= byteIdx_ff ? !rdHold_ff[15] : 1'b0;
                byteIdx_ff  <= 1'b0;
              end
            end
            default: state_ff <= state_ff;
          endcase
        end
      end
    end
  end
  // Frequency field reloads from the programming pin on every reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word0_ff <= `CCRB_CTRL0_RST;
      word1_ff <= `CCRB_CTRL1_RST | {6'h00, progFreqCode, 7'h00}; // RULE9
      word2_ff <= `CCRB_CTRL2_RST;
    end else if (wrStb_ff) begin
      case (ptr_ff)
        `CCRB_OFS_CTRL0: word0_ff <= wrData_ff & `CCRB_CTRL0_MASK; // RULE23
        `CCRB_OFS_CTRL1: word1_ff <= wrData_ff;
        `CCRB_OFS_CTRL2: word2_ff <= wrData_ff;
        default:         word0_ff <= word0_ff;
      endcase
    end
  end
  always_comb begin
    case (word1_ff[`CCRB_C1_CMPDB])
      2'h0:    cmpLimit = `CCRB_CYC_US(`CCRB_CMP_DB0_US); // RULE5
      2'h1:    cmpLimit = `CCRB_CYC_US(`CCRB_CMP_DB1_US);
      2'h2:    cmpLimit = CMP_DB2_CYC;
      default: cmpLimit = CMP_DB3_CYC;
    endcase
    case (word2_ff[`CCRB_C2_HOTDB])
      2'h0:    hotLimit = `CCRB_CYC_US(`CCRB_HOT_DB0_US); // RULE17
      2'h1:    hotLimit = `CCRB_CYC_US(`CCRB_HOT_DB1_US);
      2'h2:    hotLimit = HOT_DB2_CYC;
      default: hotLimit = HOT_DB3_CYC;
    endcase
    case (word2_ff[`CCRB_C2_HOLD])
      3'h0:    holdLimit = HOLD0_CYC; // RULE18
      3'h1:    holdLimit = HOLD1_CYC;
      3'h2:    holdLimit = HOLD2_CYC;
      3'h3:    holdLimit = HOLD3_CYC;
      3'h4:    holdLimit = HOLD4_CYC;
      3'h5:    holdLimit = HOLD5_CYC;
      3'h6:    holdLimit = `CCRB_CYC_US(`CCRB_HOLD6_US);
      default: holdLimit = `CCRB_HOLD7_CYC;
    endcase
    faultLimit = word2_ff[`CCRB_C2_FAULTSHORT] ? FAULT_SHRT_CYC : FAULT_LONG_CYC; // RULE16
    lowLimit   = `CCRB_CYC_US(`CCRB_LOW_DB_US);
  end
  ccrb_debounce cmpDebU (.core_clk(core_clk), .rst(rst), .rawIn(comparatorAbove),
                         .limit(cmpLimit), .level_ff(cmpDeb));
  ccrb_debounce faultDebU (.core_clk(core_clk), .rst(rst), .rawIn(faultReq),
                           .limit(faultLimit), .level_ff(faultDeb));
  ccrb_debounce acHotU (.core_clk(core_clk), .rst(rst), .rawIn(adapterHotReq),
                        .limit(hotLimit), .level_ff(acHotDeb));
  ccrb_debounce dcHotU (.core_clk(core_clk), .rst(rst), .rawIn(batteryHotReq),
                        .limit(hotLimit), .level_ff(dcHotDeb));
  ccrb_debounce lowHotU (.core_clk(core_clk), .rst(rst),
                         .rawIn(lowSysHotReq && word1_ff[`CCRB_C1_SUPPL]),
                         .limit(lowLimit), .level_ff(lowHotDeb)); // RULE17
  assign anyHot = acHotDeb || dcHotDeb || lowHotDeb;
  // Hold counter reloads while any source is active, runs down after release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdCnt_ff        <= 32'h0;
      processorHotOe_ff <= 1'b0;
    end else begin
      if (anyHot) begin
        holdCnt_ff <= holdLimit; // RULE18
      end else if (holdCnt_ff != 32'h0) begin
        holdCnt_ff <= holdCnt_ff - 32'h1;
      end
      processorHotOe_ff <= anyHot || (processorHotOe_ff && holdCnt_ff > 32'h1);
    end
  end
  // Exit takes priority over entry so a low battery cannot re-enter at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      learnActive_ff <= 1'b0;
    end else if (!word1_ff[`CCRB_C1_LEARN]
                 || (word1_ff[`CCRB_C1_EXITLEARN] && vbatBelowMinSys)) begin
      learnActive_ff <= 1'b0; // RULE6
    end else if (nvdcConfig && !batteryAbsentInput && batteryPresent) begin
      learnActive_ff <= 1'b1; // RULE7
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysVoltOffsetOn_ff      <= 1'b0;
      minSysOffsetOn_ff       <= 1'b0;
      reverseTurboRun_ff      <= 1'b0;
      reverseOutputOn_ff      <= 1'b0;
      supplementalOn_ff       <= 1'b0;
      switchFreqCode_ff       <= 3'h0;
      batteryFetOff_ff        <= 1'b0;
      turboAllowed_ff         <= 1'b0;
      currentMonitorOn_ff     <= 1'b0;
      monitorSelBattery_ff    <= 1'b0;
      lowSysRefCode_ff        <= 3'h0;
      trickleCode_ff          <= 3'h0;
      faultShutdown_ff        <= 1'b0;
      thermistorProfile_ff    <= 2'h0;
      thermistorSourceOn_ff   <= 1'b0;
      comparatorRefHigh_ff    <= 1'b0;
      comparatorOutput_ff     <= 1'b0;
      comparatorPinIntMode_ff <= 1'b0;
    end else begin
      sysVoltOffsetOn_ff      <= !charging && word0_ff[`CCRB_C0_OFFSET]; // RULE1
      minSysOffsetOn_ff       <= trickleCharging; // RULE2
      reverseTurboRun_ff      <= word0_ff[`CCRB_C0_REVTURBO] && hybridConfig
                                 && adapterOverLimit && !word1_ff[`CCRB_C1_FETOFF]; // RULE3
      reverseOutputOn_ff      <= word1_ff[`CCRB_C1_REVOUT]; // RULE8
      supplementalOn_ff       <= word1_ff[`CCRB_C1_SUPPL];
      switchFreqCode_ff       <= word1_ff[`CCRB_C1_FREQ]; // RULE9
      batteryFetOff_ff        <= word1_ff[`CCRB_C1_FETOFF]; // RULE11
      turboAllowed_ff         <= !word1_ff[`CCRB_C1_FETOFF]; // RULE11
      currentMonitorOn_ff     <= adapterPresent || !word1_ff[`CCRB_C1_IMONDIS]; // RULE12
      monitorSelBattery_ff    <= word1_ff[`CCRB_C1_IMONSEL]; // RULE13
      lowSysRefCode_ff        <= word1_ff[`CCRB_C1_LOWREF]; // RULE14
      trickleCode_ff          <= word2_ff[`CCRB_C2_TRICKLE]; // RULE15
      faultShutdown_ff        <= faultDeb; // RULE16
      thermistorProfile_ff    <= {word2_ff[`CCRB_C2_PROFHI], profileLowBit}; // RULE19
      thermistorSourceOn_ff   <= word2_ff[`CCRB_C2_PROFHI] || profileLowBit; // RULE19
      comparatorRefHigh_ff    <= word2_ff[`CCRB_C2_CMPREF] && adapterPresent; // RULE20
      comparatorOutput_ff     <= !word2_ff[`CCRB_C2_CMPDIS]
                                 && (cmpDeb ^ word2_ff[`CCRB_C2_CMPPOL]); // RULE22
      comparatorPinIntMode_ff <= word2_ff[`CCRB_C2_CMPDIS]; // RULE21
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  offset_adder_a: assert property (!charging && word0_ff[1] |=> sysVoltOffsetOn_ff) // RULE1
    else $error("offset adder not applied");
  trickle_offset_a: assert property (trickleCharging |=> minSysOffsetOn_ff) // RULE2
    else $error("trickle offset missing");
  reverse_turbo_a: assert property (reverseTurboRun_ff |-> $past(word0_ff[0] && hybridConfig)) // RULE3
    else $error("reverse turbo without enable");
  learn_exit_a: assert property (word1_ff[13] && vbatBelowMinSys |=> !learnActive_ff) // RULE6
    else $error("learn mode not left");
  learn_entry_a: assert property ($rose(learnActive_ff) |->
                   $past(word1_ff[12] && !batteryAbsentInput && batteryPresent)) // RULE7
    else $error("learn entered without conditions");
  fet_force_a: assert property (word1_ff[6] |=> batteryFetOff_ff && !turboAllowed_ff) // RULE11
    else $error("battery fet not forced off");
  current_monitor_function_auto_a: assert property (adapterPresent |=> currentMonitorOn_ff) // RULE12
    else $error("monitor off with adapter");
  hot_hold_a: assert property (processorHotOe_ff && holdCnt_ff > 32'h1 |=> processorHotOe_ff) // RULE18
    else $error("hot output released early");
  ref_limit_a: assert property (!adapterPresent |=> !comparatorRefHigh_ff) // RULE20
    else $error("high reference in battery-only");
  cmp_disable_a: assert property (word2_ff[3] |=> !comparatorOutput_ff && comparatorPinIntMode_ff) // RULE21
    else $error("comparator not disabled");
  reserved_zero_a: assert property (wrStb_ff |=> word0_ff[15:2] == 14'h0) // RULE23
    else $error("reserved bits stored");
endmodule

// ---- dv/ccrb_host_model.sv ----
// Bus host model: word writes and reads on the two-wire management bus.
// Assumes a pulled-up data line; sdaPull high pulls it low.
`timescale 1ns/1ps
`include "ccrb_consts.svh"
module ccrb_host_model (
  input  wire logic core_clk,
  input  wire logic sdaIn,
  output logic      sclOut,
  output logic      sdaPull
);
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Four cycles a step, clock high for four and low for eight; data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    sdaPull <= !b;
    w(4);
    sclOut <= 1'b1;
    w(4);
    r = sdaIn;
    sclOut <= 1'b0;
    w(4);
  endtask
  task automatic start();
    sdaPull <= 1'b0;
    w(4);
    sclOut <= 1'b1;
    w(4);
    sdaPull <= 1'b1;
    w(4);
    sclOut <= 1'b0;
    w(4);
  endtask
  task automatic stop();
    sdaPull <= 1'b1;
    w(4);
    sclOut <= 1'b1;
    w(4);
    sdaPull <= 1'b0;
    w(4);
  endtask
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(a, r);
  endtask
  // Whole word, low byte first
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic [7:0] q;
    start();
    xb({`CCRB_SMB_ADDR, 1'b0}, 1'b1, q);
    xb(cmd, 1'b1, q);
    xb(d[7:0], 1'b1, q);
    xb(d[15:8], 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [15:0] v);
    logic [7:0] q;
    start();
    xb({`CCRB_SMB_ADDR, 1'b0}, 1'b1, q);
    xb(cmd, 1'b1, q);
    start();
    xb({`CCRB_SMB_ADDR, 1'b1}, 1'b1, q);
    xb(8'hff, 1'b0, v[7:0]);
    xb(8'hff, 1'b1, v[15:8]);
    stop();
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the charger control register bank.
// Assumes the host model drives the bus clock and pulls the data line.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, charging = 1'b0, trickleCharging = 1'b0;
  logic hybridConfig = 1'b0, nvdcConfig = 1'b0, adapterOverLimit = 1'b0;
  logic adapterPresent = 1'b0, batteryAbsentInput = 1'b0, batteryPresent = 1'b0;
  logic vbatBelowMinSys = 1'b0, profileLowBit = 1'b0, comparatorAbove = 1'b0;
  logic adapterHotReq = 1'b0, batteryHotReq = 1'b0, lowSysHotReq = 1'b0, faultReq = 1'b0;
  logic [2:0] progFreqCode = 3'h5;
  logic smbClkIn, sdaPull, smbDatOut_ff, smbDatOe_ff, sysVoltOffsetOn_ff, minSysOffsetOn_ff;
  logic reverseTurboRun_ff, learnActive_ff, reverseOutputOn_ff, supplementalOn_ff;
  logic batteryFetOff_ff, turboAllowed_ff, currentMonitorOn_ff, monitorSelBattery_ff;
  logic faultShutdown_ff, processorHotOe_ff, thermistorSourceOn_ff, comparatorRefHigh_ff;
  logic comparatorOutput_ff, comparatorPinIntMode_ff;
  logic [2:0] switchFreqCode_ff, lowSysRefCode_ff, trickleCode_ff;
  logic [1:0] thermistorProfile_ff;
  logic [15:0] v;
  wire smbDatIn;
  int bad_count = 0;
  int tests_run = 0;
  assign smbDatIn = !(sdaPull | smbDatOe_ff);
  initial forever #25 core_clk = ~core_clk;
  ccrb_top #(.FAULT_LONG_CYC(200), .FAULT_SHRT_CYC(100), .HOLD0_CYC(60)) uut (
    .core_clk, .rst, .smbClkIn, .smbDatIn, .smbDatOut_ff, .smbDatOe_ff, .progFreqCode,
    .charging, .trickleCharging, .hybridConfig, .nvdcConfig, .adapterOverLimit,
    .adapterPresent, .batteryAbsentInput, .batteryPresent, .vbatBelowMinSys, .profileLowBit,
    .comparatorAbove, .adapterHotReq, .batteryHotReq, .lowSysHotReq, .faultReq,
    .sysVoltOffsetOn_ff, .minSysOffsetOn_ff, .reverseTurboRun_ff, .learnActive_ff,
    .reverseOutputOn_ff, .supplementalOn_ff, .switchFreqCode_ff, .batteryFetOff_ff,
    .turboAllowed_ff, .currentMonitorOn_ff, .monitorSelBattery_ff, .lowSysRefCode_ff,
    .trickleCode_ff, .faultShutdown_ff, .processorHotOe_ff, .thermistorProfile_ff,
    .thermistorSourceOn_ff, .comparatorRefHigh_ff, .comparatorOutput_ff,
    .comparatorPinIntMode_ff);
  ccrb_host_model h (.core_clk(core_clk), .sdaIn(smbDatIn), .sclOut(smbClkIn),
                     .sdaPull(sdaPull));
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic cw(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_c0();
    h.rd(8'h39, v);
    cw(v, 16'h0000);
    h.rd(8'h3a, v);
    cw(v, 16'h0000);
    h.rd(8'h3d, v);
    cw(v, 16'h6000);
    cw(16'(lowSysRefCode_ff), 16'h0003);
    // Autonomous charging off, battery healthy
    h.wr(8'h39, 16'hffff);
    h.rd(8'h39, v);
    cw(v, 16'h0003);
    cb(smbDatOut_ff, 1'b0);
    hybridConfig <= 1'b1;
    adapterOverLimit <= 1'b1;
    trickleCharging <= 1'b1;
    w(3);
    cb(sysVoltOffsetOn_ff, 1'b1);
    cb(minSysOffsetOn_ff, 1'b1);
    cb(reverseTurboRun_ff, 1'b1);
    charging <= 1'b1;
    adapterOverLimit <= 1'b0;
    w(3);
    cb(sysVoltOffsetOn_ff, 1'b0);
    cb(reverseTurboRun_ff, 1'b0);
    $display("control word zero done");
  endtask
  task automatic t_c1();
    nvdcConfig <= 1'b1;
    batteryPresent <= 1'b1;
    adapterOverLimit <= 1'b1;
    h.rd(8'h3c, v);
    cw(v, 16'h0283);
    h.wr(8'h3c, v | 16'h1877);
    h.rd(8'h3c, v);
    cw(v, 16'h1af7);
    cb(learnActive_ff, 1'b1);
    cb(reverseOutputOn_ff, 1'b1);
    cw(16'(switchFreqCode_ff), 16'h0005);
    cb(batteryFetOff_ff, 1'b1);
    cb(turboAllowed_ff, 1'b0);
    cb(reverseTurboRun_ff, 1'b0);
    cb(currentMonitorOn_ff, 1'b0);
    cb(monitorSelBattery_ff, 1'b1);
    cw(16'(lowSysRefCode_ff), 16'h0007);
    adapterPresent <= 1'b1;
    vbatBelowMinSys <= 1'b1;
    w(3);
    cb(currentMonitorOn_ff, 1'b1);
    cb(learnActive_ff, 1'b1);
    h.wr(8'h3c, 16'h3af7);
    cb(learnActive_ff, 1'b0);
    h.wr(8'h3c, 16'h0003);
    cw(16'(switchFreqCode_ff), 16'h0000);
    $display("control word one done");
  endtask
  task automatic t_c2();
    h.wr(8'h3d, 16'he834);
    h.rd(8'h3d, v);
    cw(v, 16'he834);
    cw(16'(trickleCode_ff), 16'h0007);
    cb(comparatorRefHigh_ff, 1'b1);
    cb(comparatorOutput_ff, 1'b1);
    adapterPresent <= 1'b0;
    profileLowBit <= 1'b1;
    comparatorAbove <= 1'b1;
    faultReq <= 1'b1;
    w(20);
    cb(comparatorRefHigh_ff, 1'b0);
    cw(16'(thermistorProfile_ff), 16'h0003);
    cb(thermistorSourceOn_ff, 1'b1);
    cb(comparatorOutput_ff, 1'b1);
    w(40);
    cb(comparatorOutput_ff, 1'b0);
    w(30);
    cb(faultShutdown_ff, 1'b0);
    w(20);
    cb(faultShutdown_ff, 1'b1);
    faultReq <= 1'b0;
    h.wr(8'h3d, 16'he83c);
    cb(comparatorOutput_ff, 1'b0);
    cb(comparatorPinIntMode_ff, 1'b1);
    $display("control word two done");
  endtask
  task automatic t_hot();
    batteryHotReq <= 1'b1;
    w(100);
    cb(processorHotOe_ff, 1'b0);
    w(60);
    cb(processorHotOe_ff, 1'b1);
    batteryHotReq <= 1'b0;
    w(20);
    cb(processorHotOe_ff, 1'b1);
    w(100);
    cb(processorHotOe_ff, 1'b0);
    h.wr(8'h3c, 16'h0403);
    cb(supplementalOn_ff, 1'b1);
    lowSysHotReq <= 1'b1;
    w(30);
    cb(processorHotOe_ff, 1'b0);
    w(20);
    cb(processorHotOe_ff, 1'b1);
    lowSysHotReq <= 1'b0;
    h.wr(8'h3d, 16'he9fc);
    adapterHotReq <= 1'b1;
    w(150);
    cb(processorHotOe_ff, 1'b1);
    adapterHotReq <= 1'b0;
    w(3);
    cb(processorHotOe_ff, 1'b0);
    $display("hot output done");
  endtask
  initial begin
    w(3);
    rst <= 1'b0;
    w(2);
    t_c0();
    t_c1();
    t_c2();
    t_hot();
    wrap_up();
  end
  // Tests need about 8400 cycles; give 40000, nearly five times that
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule
